// *** design/accessory_detect_pkg.sv ***
// Constants, encodings and register map for Type-C accessory detection
package accessory_detect_pkg;
	// Termination level seen on a CC line, from the analog comparators
	typedef enum logic [2:0] {
		CC_OPEN = 3'h0,
		CC_RA = 3'h1,
		CC_RD = 3'h2,
		CC_RP_DEF = 3'h3,
		CC_RP_1P5 = 3'h4,
		CC_RP_3A = 3'h5
	} cc_level_t;

	// Configured Type-C power mode
	localparam logic [2:0] MODE_SRC = 3'h0;
	localparam logic [2:0] MODE_SNK = 3'h1;
	localparam logic [2:0] MODE_DRP = 3'h2;
	localparam logic [2:0] MODE_SRC_ACC = 3'h3;
	localparam logic [2:0] MODE_SNK_ACC = 3'h4;
	localparam logic [2:0] MODE_DRP_ACC = 3'h5;
	localparam logic [2:0] MODE_DRP_ACC_TRYSRC = 3'h6;
	localparam logic [2:0] MODE_DRP_ACC_TRYSNK = 3'h7;

	// APB byte addresses
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_CONNECTION_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OPERATION_STATUS = 8'h08;
	localparam logic [7:0] ADDR_EVENT_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_EVENT_MASK = 8'h10;

	// Control register fields and reset value
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_ROLE_SRC_BIT = 4;
	localparam logic [4:0] CONTROL_RESET = 5'h00;

	// Connection status fields
	localparam int CONN_MODE_LSB = 0;
	localparam int CONN_ORIENT_BIT = 4;
	localparam logic [2:0] ATTACH_NONE = 3'h0;
	localparam logic [2:0] ATTACH_AUDIO = 3'h1;
	localparam logic [2:0] ATTACH_DEBUG = 3'h2;

	// Operation status fields
	localparam int OPER_SINK_POWER_LSB = 0;
	localparam int OPER_FSM_STATE_LSB = 4;
	localparam logic [1:0] SINK_POWER_DEFAULT = 2'h0;
	localparam logic [1:0] SINK_POWER_1P5 = 2'h1;
	localparam logic [1:0] SINK_POWER_3P0 = 2'h2;
	localparam logic [2:0] FSM_CODE_IDLE = 3'h0;
	localparam logic [2:0] FSM_CODE_UNORIENTED_SRC = 3'h1;
	localparam logic [2:0] FSM_CODE_ORIENTED_SRC = 3'h2;
	localparam logic [2:0] FSM_CODE_AUDIO = 3'h3;
	localparam logic [2:0] FSM_CODE_DEBUG_SNK = 3'h4;

	// Event status bits, same layout in the mask register
	localparam int EVENTS = 4;
	localparam int EV_AUDIO_ATTACH = 0;
	localparam int EV_DEBUG_ATTACH = 1;
	localparam int EV_DETACH = 2;
	localparam int EV_ORIENTED = 3;
	localparam logic [EVENTS-1:0] EVENT_MASK_RESET = 4'hf;

	// Synchroniser depth for comparator inputs
	localparam int SYNC_STAGES = 3;
endpackage

// *** design/cc_level_sync.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module cc_level_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [WIDTH-1:0] async_in, // Level from outside the clock domain
	output logic [WIDTH-1:0] sync_out // Settled level
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync_out;

	always_comb
	begin
		next_sync_out = sync_out;
		if (stage2 == stage3)
			next_sync_out = stage3;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_out <= next_sync_out;
		end
	end
endmodule // cc_level_sync

// *** design/event_status_irq.sv ***
// Sticky event flags, write-one-to-clear, with mask and one level interrupt
`timescale 1ns/1ns
module event_status_irq #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] MASK_RESET = '1
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic [WIDTH-1:0] event_pulse, // Hardware events
	input wire logic status_wr, // Write to status register
	input wire logic mask_wr, // Write to mask register
	input wire logic [WIDTH-1:0] wdata, // Write data
	output logic [WIDTH-1:0] status, // Sticky flags
	output logic [WIDTH-1:0] mask, // One masks a flag
	output logic irq // Level interrupt
);
	logic [WIDTH-1:0] next_status;
	logic [WIDTH-1:0] next_mask;

	always_comb
	begin
		next_status = status;
		next_mask = mask;
		if (status_wr)
			next_status = status & ~wdata;
		// Set beats a clear in the same cycle
		next_status = next_status | event_pulse;
		if (mask_wr)
			next_mask = wdata;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			status <= '0;
			mask <= MASK_RESET;
		end
		else
		begin
			status <= next_status;
			mask <= next_mask;
		end
	end

	assign irq = |(status & ~mask);

	AST_EVENT_STICKS: assert property (@(posedge clk) disable iff (sys_rst)
		(event_pulse != '0) |=> ((status & $past(event_pulse)) == $past(event_pulse)))
		else $error("Event flag not set after event");
endmodule // event_status_irq

// *** design/type_c_accessory_detect.sv ***
// Type-C audio and debug accessory detection with APB status registers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module type_c_accessory_detect (
	input wire logic clk, // Core clock, 125 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire accessory_detect_pkg::cc_level_t cc1_level, // CC1 comparator code
	input wire accessory_detect_pkg::cc_level_t cc2_level, // CC2 comparator code
	output logic sink_debug_indicate, // Debug accessory found in sink role
	output logic source_debug_indicate, // Debug accessory found in source role
	output logic orient_out, // Orientation pin output level
	output logic orient_oe, // Orientation pin driven when high
	output logic irq // Event interrupt, level
);
	import accessory_detect_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_AUDIO,
		ST_DEBUG_SNK,
		ST_UNORIENTED_SRC,
		ST_ORIENTED_SRC
	} detect_state_t;

	detect_state_t state;
	detect_state_t next_state;
	logic [2:0] cc1_sync;
	logic [2:0] cc2_sync;
	cc_level_t cc1;
	cc_level_t cc2;
	logic [4:0] control;
	logic [4:0] next_control;
	logic [2:0] power_mode;
	logic role_source;
	logic acc_enabled;
	logic [1:0] sink_power;
	logic [1:0] next_sink_power;
	logic orient_drive;
	logic next_orient_drive;
	logic [EVENTS-1:0] event_pulse;
	logic [EVENTS-1:0] ev_status;
	logic [EVENTS-1:0] ev_mask;
	logic [31:0] next_prdata;
	logic [2:0] attached_mode_field;
	logic [2:0] port_fsm_state_field;
	logic [31:0] connection_status_reg;
	logic [31:0] operation_status_reg;
	logic setup_phase;
	logic wr_access;
	logic addr_hit;

	function automatic logic is_rp(input cc_level_t lvl);
		return (lvl == CC_RP_DEF) || (lvl == CC_RP_1P5) || (lvl == CC_RP_3A);
	endfunction

	// Current advertised by a pair of Rp levels
	function automatic logic [1:0] rp_capability(input cc_level_t hi, input cc_level_t lo);
		logic [1:0] cap;
		cap = SINK_POWER_DEFAULT;
		if (hi == CC_RP_1P5 && lo == CC_RP_DEF)
			cap = SINK_POWER_1P5;
		else if (hi == CC_RP_3A && lo == CC_RP_DEF)
			cap = SINK_POWER_3P0;
		return cap;
	endfunction

	cc_level_sync #(
		.WIDTH(3)
	) u_sync_cc1 (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(cc1_level),
		.sync_out(cc1_sync)
	);

	cc_level_sync #(
		.WIDTH(3)
	) u_sync_cc2 (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(cc2_level),
		.sync_out(cc2_sync)
	);

	assign cc1 = cc_level_t'(cc1_sync);
	assign cc2 = cc_level_t'(cc2_sync);

	assign power_mode = control[CTRL_MODE_LSB +: 3];
	assign role_source = control[CTRL_ROLE_SRC_BIT];
	assign acc_enabled = (power_mode == MODE_SRC_ACC) || (power_mode == MODE_SNK_ACC) ||
		(power_mode == MODE_DRP_ACC) || (power_mode == MODE_DRP_ACC_TRYSRC) ||
		(power_mode == MODE_DRP_ACC_TRYSNK);

	// Detection state machine
	always_comb
	begin
		next_state = state;
		next_sink_power = sink_power;
		next_orient_drive = orient_drive;
		unique case (state)
			ST_IDLE:
			begin
				next_sink_power = SINK_POWER_DEFAULT;
				next_orient_drive = 1'b0;
				if (acc_enabled)
				begin
					if (cc1 == CC_RA && cc2 == CC_RA)
						next_state = ST_AUDIO;
					else if (!role_source && is_rp(cc1) && is_rp(cc2))
						next_state = ST_DEBUG_SNK;
					else if (role_source && cc1 == CC_RD && cc2 == CC_RD)
						next_state = ST_UNORIENTED_SRC;
				end
			end
			ST_AUDIO:
			begin
				if (!acc_enabled || cc1 != CC_RA || cc2 != CC_RA)
					next_state = ST_IDLE;
			end
			ST_DEBUG_SNK:
			begin
				if (!acc_enabled || role_source || !is_rp(cc1) || !is_rp(cc2))
				begin
					next_state = ST_IDLE;
					next_sink_power = SINK_POWER_DEFAULT;
					next_orient_drive = 1'b0;
				end
				else if (cc1 > cc2)
				begin
					// CC1 higher: pin left floating
					next_sink_power = rp_capability(cc1, cc2);
					next_orient_drive = 1'b0;
				end
				else if (cc2 > cc1)
				begin
					next_sink_power = rp_capability(cc2, cc1);
					next_orient_drive = 1'b1;
				end
				else
				begin
					next_sink_power = SINK_POWER_DEFAULT;
					next_orient_drive = 1'b0;
				end
			end
			ST_UNORIENTED_SRC:
			begin
				next_orient_drive = 1'b0;
				if (!acc_enabled || !role_source)
					next_state = ST_IDLE;
				else if (cc1 == CC_RD && cc2 == CC_RA)
					next_state = ST_ORIENTED_SRC;
				else if (cc2 == CC_RD && cc1 == CC_RA)
				begin
					next_state = ST_ORIENTED_SRC;
					next_orient_drive = 1'b1;
				end
				else if (cc1 != CC_RD || cc2 != CC_RD)
					next_state = ST_IDLE;
			end
			ST_ORIENTED_SRC:
			begin
				if (!acc_enabled || !role_source)
					next_state = ST_IDLE;
				else if (cc1 == CC_RD && cc2 == CC_RD)
					next_state = ST_UNORIENTED_SRC;
				else if (!((cc1 == CC_RD && cc2 == CC_RA) || (cc2 == CC_RD && cc1 == CC_RA)))
					next_state = ST_IDLE;
				// Follow a side swap without passing through unoriented
				next_orient_drive = (next_state == ST_ORIENTED_SRC) && (cc1 == CC_RA);
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			sink_power <= SINK_POWER_DEFAULT;
			orient_drive <= 1'b0;
		end
		else
		begin
			state <= next_state;
			sink_power <= next_sink_power;
			orient_drive <= next_orient_drive;
		end
	end

	// Pins follow the registered state
	always_comb
	begin
		sink_debug_indicate = (state == ST_DEBUG_SNK);
		source_debug_indicate = (state == ST_UNORIENTED_SRC) ||
			(state == ST_ORIENTED_SRC);
		orient_oe = orient_drive;
		orient_out = 1'b0;
	end

	// Status fields
	always_comb
	begin
		attached_mode_field = ATTACH_NONE;
		port_fsm_state_field = FSM_CODE_IDLE;
		unique case (state)
			ST_IDLE:
				port_fsm_state_field = FSM_CODE_IDLE;
			ST_AUDIO:
			begin
				attached_mode_field = ATTACH_AUDIO;
				port_fsm_state_field = FSM_CODE_AUDIO;
			end
			ST_DEBUG_SNK:
			begin
				attached_mode_field = ATTACH_DEBUG;
				port_fsm_state_field = FSM_CODE_DEBUG_SNK;
			end
			ST_UNORIENTED_SRC:
			begin
				attached_mode_field = ATTACH_DEBUG;
				port_fsm_state_field = FSM_CODE_UNORIENTED_SRC;
			end
			ST_ORIENTED_SRC:
			begin
				attached_mode_field = ATTACH_DEBUG;
				port_fsm_state_field = FSM_CODE_ORIENTED_SRC;
			end
		endcase
		connection_status_reg = '0;
		connection_status_reg[CONN_MODE_LSB +: 3] = attached_mode_field;
		connection_status_reg[CONN_ORIENT_BIT] = orient_drive;
		operation_status_reg = '0;
		operation_status_reg[OPER_SINK_POWER_LSB +: 2] = sink_power;
		operation_status_reg[OPER_FSM_STATE_LSB +: 3] = port_fsm_state_field;
	end

	// Events raised on state entries
	always_comb
	begin
		event_pulse = '0;
		event_pulse[EV_AUDIO_ATTACH] = (next_state == ST_AUDIO) && (state == ST_IDLE);
		event_pulse[EV_DEBUG_ATTACH] = (state == ST_IDLE) &&
			((next_state == ST_DEBUG_SNK) || (next_state == ST_UNORIENTED_SRC));
		event_pulse[EV_DETACH] = (state != ST_IDLE) && (next_state == ST_IDLE);
		event_pulse[EV_ORIENTED] = (state == ST_UNORIENTED_SRC) &&
			(next_state == ST_ORIENTED_SRC);
	end

	// APB slave, zero wait states
	assign setup_phase = psel && !penable;
	assign wr_access = psel && penable && pwrite && addr_hit;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	always_comb
	begin
		addr_hit = (paddr == ADDR_CONTROL) || (paddr == ADDR_CONNECTION_STATUS) ||
			(paddr == ADDR_OPERATION_STATUS) || (paddr == ADDR_EVENT_STATUS) ||
			(paddr == ADDR_EVENT_MASK);
		next_control = control;
		if (wr_access && paddr == ADDR_CONTROL)
			next_control = pwdata[4:0];
		next_prdata = prdata;
		if (setup_phase)
		begin
			next_prdata = '0;
			if (paddr == ADDR_CONTROL)
				next_prdata = {27'h0, control};
			else if (paddr == ADDR_CONNECTION_STATUS)
				next_prdata = connection_status_reg;
			else if (paddr == ADDR_OPERATION_STATUS)
				next_prdata = operation_status_reg;
			else if (paddr == ADDR_EVENT_STATUS)
				next_prdata = {28'h0000000, ev_status};
			else if (paddr == ADDR_EVENT_MASK)
				next_prdata = {28'h0000000, ev_mask};
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			control <= CONTROL_RESET;
			prdata <= '0;
		end
		else
		begin
			control <= next_control;
			prdata <= next_prdata;
		end
	end

	event_status_irq #(
		.WIDTH(EVENTS),
		.MASK_RESET(EVENT_MASK_RESET)
	) u_events (
		.clk(clk),
		.sys_rst(sys_rst),
		.event_pulse(event_pulse),
		.status_wr(wr_access && paddr == ADDR_EVENT_STATUS),
		.mask_wr(wr_access && paddr == ADDR_EVENT_MASK),
		.wdata(pwdata[EVENTS-1:0]),
		.status(ev_status),
		.mask(ev_mask),
		.irq(irq)
	);

	AST_NO_DETECT_WITHOUT_ACC: assert property (@(posedge clk) disable iff (sys_rst)
		!acc_enabled |=> (state == ST_IDLE) || $past(state) != ST_IDLE)
		else $error("Detection left idle without accessory mode");
	AST_AUDIO_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_IDLE && acc_enabled && cc1 == CC_RA && cc2 == CC_RA) |=>
		(state == ST_AUDIO))
		else $error("Audio accessory not declared");
	AST_AUDIO_FIELD: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_AUDIO) |-> (connection_status_reg[2:0] == ATTACH_AUDIO))
		else $error("Audio attach not reported");
	AST_SNK_ROLE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(sink_debug_indicate) |-> !$past(role_source))
		else $error("Sink debug raised in source role");
	AST_DEBUG_PINS_FIELD: assert property (@(posedge clk) disable iff (sys_rst)
		(sink_debug_indicate || source_debug_indicate) |->
		(attached_mode_field == ATTACH_DEBUG) && !(sink_debug_indicate && source_debug_indicate))
		else $error("Debug pins and field disagree");
	AST_SNK_DEBUG_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_IDLE && acc_enabled && !role_source && is_rp(cc1) && is_rp(cc2) &&
		!(cc1 == CC_RA && cc2 == CC_RA)) |=> sink_debug_indicate)
		else $error("Sink debug accessory not declared");
	AST_SNK_3A: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_DEBUG_SNK && next_state == ST_DEBUG_SNK && cc2 == CC_RP_3A &&
		cc1 == CC_RP_DEF) |=> (sink_power == SINK_POWER_3P0) && orient_oe)
		else $error("Sink 3.0 A mapping wrong");
	AST_SRC_DEBUG_ENTRY: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_IDLE && acc_enabled && role_source && cc1 == CC_RD && cc2 == CC_RD)
		|=> source_debug_indicate && !orient_oe)
		else $error("Source debug accessory not declared");
	AST_SRC_ORIENT: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_UNORIENTED_SRC && acc_enabled && role_source && cc2 == CC_RD &&
		cc1 == CC_RA) |=> (port_fsm_state_field == FSM_CODE_ORIENTED_SRC) && orient_oe)
		else $error("Source orientation not resolved");
	AST_DETACH_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
		(state != ST_IDLE && next_state == ST_IDLE) |=> (!orient_oe &&
		!sink_debug_indicate && !source_debug_indicate && attached_mode_field == ATTACH_NONE))
		else $error("Outputs not released after detach");
endmodule // type_c_accessory_detect

// *** tb/cc_accessory_model.sv ***
// Accessory on the far side of the CC pins, presenting its terminations
`timescale 1ns/1ns
module cc_accessory_model (
	input wire logic clk, // Core clock
	input wire accessory_detect_pkg::cc_level_t term1, // Termination wanted on CC1
	input wire accessory_detect_pkg::cc_level_t term2, // Termination wanted on CC2
	input wire logic slow, // Terminations settle two cycles later
	output accessory_detect_pkg::cc_level_t cc1_level, // Level seen on CC1
	output accessory_detect_pkg::cc_level_t cc2_level // Level seen on CC2
);
	import accessory_detect_pkg::*;
	cc_level_t d1a;
	cc_level_t d1b;
	cc_level_t d2a;
	cc_level_t d2b;
	// Slow accessory connects its terminations late
	always @(posedge clk)
	begin
		d1a <= term1;
		d1b <= d1a;
		d2a <= term2;
		d2b <= d2a;
		cc1_level <= slow ? d1b : term1;
		cc2_level <= slow ? d2b : term2;
	end
endmodule // cc_accessory_model

// *** tb/type_c_accessory_detect_tb_top.sv ***
// Self-checking bench for Type-C accessory detection
`timescale 1ns/1ns
module type_c_accessory_detect_tb_top;
	import accessory_detect_pkg::*;
	typedef struct {
		logic [2:0] mode;
		logic role;
		cc_level_t c1;
		cc_level_t c2;
		logic [2:0] pins;
		logic [2:0] att;
		logic [1:0] pwr;
		logic [2:0] fsm;
		logic keep;
	} row_t;
	// Pins are {sink debug, source debug, orientation enable}
	row_t rows [19] = '{
		'{MODE_SNK_ACC, 1'b0, CC_RP_3A, CC_RP_DEF, 3'h4,
			ATTACH_DEBUG, SINK_POWER_3P0, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_SNK_ACC, 1'b0, CC_RP_DEF, CC_RP_3A, 3'h5,
			ATTACH_DEBUG, SINK_POWER_3P0, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_SNK_ACC, 1'b0, CC_RP_1P5, CC_RP_DEF, 3'h4,
			ATTACH_DEBUG, SINK_POWER_1P5, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_DRP_ACC_TRYSNK, 1'b0, CC_RP_DEF, CC_RP_1P5, 3'h5,
			ATTACH_DEBUG, SINK_POWER_1P5, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_SNK_ACC, 1'b0, CC_RP_3A, CC_RP_1P5, 3'h4,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_DRP_ACC, 1'b0, CC_RP_1P5, CC_RP_3A, 3'h5,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_SNK_ACC, 1'b0, CC_RP_3A, CC_RP_3A, 3'h4,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_DEBUG_SNK, 1'b0},
		'{MODE_SRC_ACC, 1'b1, CC_RD, CC_RD, 3'h2,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_UNORIENTED_SRC, 1'b1},
		'{MODE_SRC_ACC, 1'b1, CC_RD, CC_RA, 3'h2,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_ORIENTED_SRC, 1'b1},
		'{MODE_SRC_ACC, 1'b1, CC_RD, CC_RD, 3'h2,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_UNORIENTED_SRC, 1'b1},
		'{MODE_SRC_ACC, 1'b1, CC_RA, CC_RD, 3'h3,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_ORIENTED_SRC, 1'b0},
		'{MODE_DRP_ACC_TRYSRC, 1'b1, CC_RD, CC_RD, 3'h2,
			ATTACH_DEBUG, SINK_POWER_DEFAULT, FSM_CODE_UNORIENTED_SRC, 1'b0},
		'{MODE_SNK_ACC, 1'b1, CC_RP_3A, CC_RP_DEF, 3'h0,
			ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0},
		'{MODE_SRC_ACC, 1'b0, CC_RD, CC_RD, 3'h0,
			ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0},
		'{MODE_SNK, 1'b0, CC_RP_3A, CC_RP_DEF, 3'h0,
			ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0},
		'{MODE_SRC, 1'b1, CC_RD, CC_RD, 3'h0,
			ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0},
		'{MODE_DRP, 1'b1, CC_RA, CC_RA, 3'h0,
			ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0},
		'{MODE_SRC_ACC, 1'b1, CC_RA, CC_RA, 3'h0,
			ATTACH_AUDIO, SINK_POWER_DEFAULT, FSM_CODE_AUDIO, 1'b0},
		'{MODE_SNK_ACC, 1'b0, CC_RA, CC_RA, 3'h0,
			ATTACH_AUDIO, SINK_POWER_DEFAULT, FSM_CODE_AUDIO, 1'b0}
	};
	row_t gone = '{MODE_SRC, 1'b0, CC_OPEN, CC_OPEN, 3'h0,
		ATTACH_NONE, SINK_POWER_DEFAULT, FSM_CODE_IDLE, 1'b0};
	logic clk;
	logic sys_rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	cc_level_t term1;
	cc_level_t term2;
	cc_level_t cc1_level;
	cc_level_t cc2_level;
	logic slow;
	logic sink_debug_indicate;
	logic source_debug_indicate;
	logic orient_out;
	logic orient_oe;
	logic irq;
	logic [31:0] d;
	logic e;
	int n_fail = 0;
	int tests_run = 0;

	type_c_accessory_detect dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cc1_level(cc1_level),
		.cc2_level(cc2_level), .sink_debug_indicate(sink_debug_indicate),
		.source_debug_indicate(source_debug_indicate), .orient_out(orient_out),
		.orient_oe(orient_oe), .irq(irq));
	cc_accessory_model acc (.clk(clk), .term1(term1), .term2(term2), .slow(slow),
		.cc1_level(cc1_level), .cc2_level(cc2_level));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task conclude();
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 16)
		begin
			n_fail++;
			conclude();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, wd, r, er);
	endtask

	task automatic settle();
		repeat (10) @(posedge clk);
	endtask

	task automatic check_state(input row_t r);
		check("sink_debug_indicate", 32'(r.pins[2]), 32'(sink_debug_indicate));
		check("source_debug_indicate", 32'(r.pins[1]), 32'(source_debug_indicate));
		check("orient_oe", 32'(r.pins[0]), 32'(orient_oe));
		check("orient_out", 32'h0, 32'(orient_out));
		check("irq", 32'h0, 32'(irq));
		apb(1'b0, ADDR_CONNECTION_STATUS, 32'h0, d, e);
		check("connection", {27'h0, r.pins[0], 1'b0, r.att}, d);
		apb(1'b0, ADDR_OPERATION_STATUS, 32'h0, d, e);
		check("fsm state", 32'(r.fsm), 32'(d[6:4]));
		if (r.pins[2])
			check("sink power", 32'(r.pwr), 32'(d[1:0]));
	endtask

	initial
	begin
		sys_rst = 1'b1;
		{psel, penable, pwrite, slow} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		term1 = CC_OPEN;
		term2 = CC_OPEN;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		settle();
		check_state(gone);
		apb(1'b0, ADDR_CONTROL, 32'h0, d, e);
		check("control", 32'(CONTROL_RESET), d);
		apb(1'b0, ADDR_EVENT_MASK, 32'h0, d, e);
		check("mask", 32'(EVENT_MASK_RESET), d);
		wr(8'h14, 32'h7);
		apb(1'b0, 8'h14, 32'h0, d, e);
		check("unmapped data", 32'h0, d);
		check("unmapped error", 32'h1, 32'(e));
		foreach (rows[i])
		begin
			wr(ADDR_CONTROL, {27'h0, rows[i].role, 1'b0, rows[i].mode});
			term1 <= rows[i].c1;
			term2 <= rows[i].c2;
			settle();
			check_state(rows[i]);
			if (!rows[i].keep)
			begin
				term1 <= CC_OPEN;
				term2 <= CC_OPEN;
				settle();
				check_state(gone);
			end
		end
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0, d, e);
		check("event status", 32'hf, d);
		wr(ADDR_EVENT_STATUS, 32'hf);
		wr(ADDR_EVENT_MASK, 32'h0);
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0, d, e);
		check("event cleared", 32'h0, d);
		slow <= 1'b1;
		wr(ADDR_CONTROL, {27'h0, 1'b1, 1'b0, MODE_SRC_ACC});
		term1 <= CC_RA;
		term2 <= CC_RA;
		settle();
		check("irq audio", 32'h1, 32'(irq));
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0, d, e);
		check("audio event", 32'h1, d);
		wr(ADDR_EVENT_MASK, 32'h1);
		repeat (2) @(posedge clk);
		check("irq masked", 32'h0, 32'(irq));
		wr(ADDR_EVENT_STATUS, 32'h1);
		wr(ADDR_EVENT_MASK, 32'h0);
		repeat (2) @(posedge clk);
		check("irq cleared", 32'h0, 32'(irq));
		term1 <= CC_OPEN;
		term2 <= CC_OPEN;
		settle();
		check("irq detach", 32'h1, 32'(irq));
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0, d, e);
		check("detach event", 32'h4, d);
		wr(ADDR_CONTROL, {27'h0, 1'b1, 1'b0, MODE_SRC_ACC});
		term1 <= CC_RD;
		term2 <= CC_RD;
		settle();
		check("source debug before reset", 32'h1, 32'(source_debug_indicate));
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		settle();
		check_state(gone);
		apb(1'b0, ADDR_EVENT_MASK, 32'h0, d, e);
		check("mask after reset", 32'(EVENT_MASK_RESET), d);
		conclude();
	end
endmodule // type_c_accessory_detect_tb_top
